// [hw/lps_pkg.sv]
package lps_pkg;

  // Timebase
  localparam int unsigned CLK_HZ      = 25_000_000;
  localparam int unsigned TICK_MS     = 100;
  localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;

  // Sizes
  localparam int unsigned NUM_PROG  = 12;
  localparam int unsigned NUM_STEP  = 10;
  localparam int unsigned NUM_SLOT  = 120;
  localparam int unsigned NUM_CH    = 8;
  localparam int unsigned MAX_TICKS = 600;
  localparam int unsigned NUM_ENTRY = NUM_PROG * NUM_STEP;

  // Register byte offsets
  localparam logic [5:0] ADDR_CTRL   = 6'h00;
  localparam logic [5:0] ADDR_STATUS = 6'h04;
  localparam logic [5:0] ADDR_SEL    = 6'h08;
  localparam logic [5:0] ADDR_STEP_A = 6'h0C;
  localparam logic [5:0] ADDR_STEP_B = 6'h10;
  localparam logic [5:0] ADDR_STEP_C = 6'h14;
  localparam logic [5:0] ADDR_CHAIN  = 6'h18;
  localparam logic [5:0] ADDR_START  = 6'h1C;
  localparam logic [5:0] ADDR_CFG    = 6'h20;

  // Command bits of the control register
  localparam int unsigned CTRL_RUN_BIT  = 0;
  localparam int unsigned CTRL_NEXT_BIT = 1;
  localparam int unsigned CTRL_STOP_BIT = 2;
  localparam int unsigned CTRL_CLR_BIT  = 3;

  // Field positions
  localparam int unsigned SEL_PROG_LSB  = 0;
  localparam int unsigned SEL_STEP_LSB  = 4;
  localparam int unsigned A_SLOT_LSB    = 0;
  localparam int unsigned A_RUN_LSB     = 8;
  localparam int unsigned A_CH_LSB      = 12;
  localparam int unsigned B_ON_LSB      = 0;
  localparam int unsigned B_OFF_LSB     = 16;
  localparam int unsigned C_SHORT_LSB   = 0;
  localparam int unsigned C_PF_LSB      = 16;
  localparam int unsigned ST_RUN_BIT    = 0;
  localparam int unsigned ST_WAIT_BIT   = 1;
  localparam int unsigned ST_REJ_BIT    = 2;
  localparam int unsigned ST_DONE_BIT   = 3;
  localparam int unsigned ST_PROG_LSB   = 4;
  localparam int unsigned ST_STEP_LSB   = 8;
  localparam int unsigned ST_ELAPS_LSB  = 16;
  localparam int unsigned CFG_LIMIT_BIT = 0;

  typedef enum logic [1:0] {
    RUN_SKIP   = 2'h0,
    RUN_AUTO   = 2'h1,
    RUN_MANUAL = 2'h2
  } lps_run_t;

  typedef struct packed {
    logic [6:0] slot;
    lps_run_t   run;
    logic [3:0] ch;
    logic [9:0] on_t;
    logic [9:0] off_t;
    logic [9:0] short_t;
    logic [9:0] pf_t;
  } lps_step_t;

  // Reset values
  localparam lps_step_t  STEP_RST  = '{slot: 7'h01, run: RUN_SKIP, ch: 4'h0, on_t: 10'h001,
                                       off_t: 10'h000, short_t: 10'h000, pf_t: 10'h000};
  localparam logic [3:0] LINK_END  = 4'h0;
  localparam logic [3:0] START_RST = 4'h0;

  typedef enum logic [4:0] {
    ST_IDLE  = 5'h01,
    ST_FETCH = 5'h02,
    ST_WAIT  = 5'h04,
    ST_ON    = 5'h08,
    ST_OFF   = 5'h10
  } lps_state_t;

endpackage : lps_pkg

// [hw/lps_tick.sv]
module lps_tick #(
  parameter int unsigned TICK_CYCLES = lps_pkg::TICK_CYCLES
) (
  input  wire logic CORE_CLK,  // Core clock
  input  wire logic RST_B,     // Async reset, active low
  input  wire logic clr,       // Restart the tenth-second period
  output logic      tick       // One-cycle pulse each period
);

  typedef struct packed {
    logic [21:0] cnt;
  } lps_tick_t;

  lps_tick_t s;
  lps_tick_t n;

  // Period counter, restarted at each step start
  always_comb begin
    n = s;
    tick = (s.cnt == 22'(TICK_CYCLES - 1)) && !clr;
    if (clr || tick) begin
      n.cnt = 22'h000000;
    end else begin
      n.cnt = s.cnt + 22'h000001;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

endmodule : lps_tick

// [hw/lps_seq.sv]
// Notes on behaviour
// RULE1: Twelve programs, ten steps, operator selects one.
// RULE2: Step recalls one of 120 setting slots.
// RULE3: Executing step loads all channels together.
// RULE4: Steps run in ascending order from first.
// RULE5: Run is skip, automatic or manual.
// RULE6: Unused steps default to skip.
// RULE7: Load-on time 0.1 to 60 s.
// RULE8: Optional load-off time follows load-on.
// RULE9: Short time rejected above load-on time.
// RULE10: Short circuit starts with load-on.
// RULE11: One short channel or none.
// RULE12: Judgement delay off or below total time.
// RULE13: Limit check continues without judgement delay.
// RULE14: Programs chain, up to twelve.
// RULE15: Chain follows links, any order.
// RULE16: End marker link terminates the chain.
// RULE17: Backward links loop until stopped.
// RULE18: Manual step waits for next command.
// RULE19: Stop aborts immediately.
// RULE20: Durations counted in tenth-second ticks.
module lps_seq #(
  parameter int unsigned TICK_CYCLES = lps_pkg::TICK_CYCLES
) (
  input  wire logic        CORE_CLK,         // Core clock, 25 MHz
  input  wire logic        RST_B,            // Async reset, active low
  input  wire logic [5:0]  ADDR,             // Register byte address
  input  wire logic [31:0] WDATA,            // Write data
  input  wire logic        WR_STB,           // Write strobe
  input  wire logic        RD_STB,           // Read strobe
  output logic      [31:0] RDATA,            // Read data, cycle after strobe
  output logic             LOAD_ON,          // All channels loaded
  output logic      [6:0]  SETTING_SLOT,     // Recalled stored_setting_slot
  output logic      [7:0]  SHORT_EN,         // Short per channel
  output logic             JUDGE_PULSE,      // Pass/fail judgement instant
  output logic             LIMIT_CHECK_ACT,  // limit_check active
  output logic             RUNNING,          // Program running
  output logic             WAIT_NEXT         // Held at manual step
);

  typedef struct packed {
    lps_pkg::lps_state_t                                st;
    lps_pkg::lps_step_t [lps_pkg::NUM_ENTRY-1:0]        steps;
    logic [lps_pkg::NUM_PROG-1:0][3:0]                  link;
    logic [3:0]                                         start;
    logic [3:0]                                         sel_prog;
    logic [3:0]                                         sel_step;
    logic [3:0]                                         cur_prog;
    logic [3:0]                                         cur_step;
    logic [10:0]                                        elapsed;
    logic                                               rej;
    logic                                               done;
    logic                                               lim_en;
    logic                                               judge;
    logic [6:0]                                         slot;
    logic [7:0]                                         short_mask;
    logic [31:0]                                        rdata;
  } lps_seq_t;

  lps_seq_t           s;
  lps_seq_t           n;
  lps_pkg::lps_step_t cur;
  lps_pkg::lps_step_t nx;
  logic               tick;
  logic               tick_clr;
  logic               run_cmd;
  logic               next_cmd;
  logic               stop_cmd;
  logic               clr_cmd;
  logic               adv;
  logic [10:0]        e1;
  logic [6:0]         wsel;
  logic [9:0]         w_on;
  logic [9:0]         w_off;
  logic [9:0]         w_sc;
  logic [9:0]         w_pf;
  logic [6:0]         w_slot;
  logic [1:0]         w_run;
  logic [3:0]         w_ch;

  function automatic logic [6:0] step_idx(input logic [3:0] p, input logic [3:0] q);
    step_idx = 7'(p) * 7'(lps_pkg::NUM_STEP) + 7'(q);
  endfunction : step_idx

  lps_tick #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_tick (
    .CORE_CLK (CORE_CLK),
    .RST_B    (RST_B),
    .clr      (tick_clr),
    .tick     (tick)
  );

  // Command strobes decoded from control writes
  assign run_cmd  = WR_STB && (ADDR == lps_pkg::ADDR_CTRL) && WDATA[lps_pkg::CTRL_RUN_BIT];
  assign next_cmd = WR_STB && (ADDR == lps_pkg::ADDR_CTRL) && WDATA[lps_pkg::CTRL_NEXT_BIT];
  assign stop_cmd = WR_STB && (ADDR == lps_pkg::ADDR_CTRL) && WDATA[lps_pkg::CTRL_STOP_BIT];
  assign clr_cmd  = WR_STB && (ADDR == lps_pkg::ADDR_CTRL) && WDATA[lps_pkg::CTRL_CLR_BIT];

  // Write field slices
  assign w_slot = WDATA[lps_pkg::A_SLOT_LSB +: 7];
  assign w_run  = WDATA[lps_pkg::A_RUN_LSB +: 2];
  assign w_ch   = WDATA[lps_pkg::A_CH_LSB +: 4];
  assign w_on   = WDATA[lps_pkg::B_ON_LSB +: 10];
  assign w_off  = WDATA[lps_pkg::B_OFF_LSB +: 10];
  assign w_sc   = WDATA[lps_pkg::C_SHORT_LSB +: 10];
  assign w_pf   = WDATA[lps_pkg::C_PF_LSB +: 10];

  // Register file, sequencer and output staging
  always_comb begin
    n        = s;
    n.judge  = 1'b0;
    n.rdata  = 32'h00000000;
    tick_clr = 1'b0;
    adv      = 1'b0;
    wsel     = step_idx(s.sel_prog, s.sel_step);
    cur      = s.steps[step_idx(s.cur_prog, s.cur_step)];
    e1       = s.elapsed + 11'h001;
    if (clr_cmd) begin
      n.rej = 1'b0;
    end
    if (WR_STB) begin
      case (ADDR)
        lps_pkg::ADDR_SEL: begin
          if (WDATA[lps_pkg::SEL_PROG_LSB +: 4] < 4'(lps_pkg::NUM_PROG) &&
              WDATA[lps_pkg::SEL_STEP_LSB +: 4] < 4'(lps_pkg::NUM_STEP)) begin  // [RULE1]
            n.sel_prog = WDATA[lps_pkg::SEL_PROG_LSB +: 4];
            n.sel_step = WDATA[lps_pkg::SEL_STEP_LSB +: 4];
          end else begin
            n.rej = 1'b1;
          end
        end
        lps_pkg::ADDR_STEP_A: begin
          if (w_slot != 7'h00 && w_slot <= 7'(lps_pkg::NUM_SLOT) &&                // [RULE2]
              w_run != 2'h3 && w_ch <= 4'(lps_pkg::NUM_CH)) begin                  // [RULE5] [RULE11]
            n.steps[wsel].slot = w_slot;
            n.steps[wsel].run  = lps_pkg::lps_run_t'(w_run);
            n.steps[wsel].ch   = w_ch;
          end else begin
            n.rej = 1'b1;
          end
        end
        lps_pkg::ADDR_STEP_B: begin
          if (w_on != 10'h000 && w_on <= 10'(lps_pkg::MAX_TICKS) &&                // [RULE7]
              w_off <= 10'(lps_pkg::MAX_TICKS) &&                                  // [RULE8]
              s.steps[wsel].short_t <= w_on &&                                     // [RULE9]
              11'(s.steps[wsel].pf_t) < 11'(w_on) + 11'(w_off)) begin              // [RULE12]
            n.steps[wsel].on_t  = w_on;
            n.steps[wsel].off_t = w_off;
          end else begin
            n.rej = 1'b1;
          end
        end
        lps_pkg::ADDR_STEP_C: begin
          if (w_sc <= s.steps[wsel].on_t &&                                        // [RULE9]
              11'(w_pf) < 11'(s.steps[wsel].on_t) + 11'(s.steps[wsel].off_t)) begin // [RULE12]
            n.steps[wsel].short_t = w_sc;
            n.steps[wsel].pf_t    = w_pf;
          end else begin
            n.rej = 1'b1;
          end
        end
        lps_pkg::ADDR_CHAIN: begin
          if (WDATA[3:0] <= 4'(lps_pkg::NUM_PROG)) begin                           // [RULE14]
            n.link[s.sel_prog] = WDATA[3:0];
          end else begin
            n.rej = 1'b1;
          end
        end
        lps_pkg::ADDR_START: begin
          if (WDATA[3:0] < 4'(lps_pkg::NUM_PROG)) begin
            n.start = WDATA[3:0];
          end else begin
            n.rej = 1'b1;
          end
        end
        lps_pkg::ADDR_CFG: begin
          n.lim_en = WDATA[lps_pkg::CFG_LIMIT_BIT];
        end
        default: begin
        end
      endcase
    end
    // Step sequencing
    unique case (s.st)
      lps_pkg::ST_IDLE: begin
        if (run_cmd) begin
          n.cur_prog = s.start;
          n.cur_step = 4'h0;                                                       // [RULE4]
          n.done     = 1'b0;
          n.st       = lps_pkg::ST_FETCH;
        end
      end
      lps_pkg::ST_FETCH: begin
        unique case (cur.run)
          lps_pkg::RUN_SKIP: adv = 1'b1;                                           // [RULE5] [RULE6]
          lps_pkg::RUN_MANUAL: n.st = lps_pkg::ST_WAIT;                            // [RULE18]
          lps_pkg::RUN_AUTO: begin
            n.st      = lps_pkg::ST_ON;
            n.elapsed = 11'h000;
            tick_clr  = 1'b1;
          end
        endcase
      end
      lps_pkg::ST_WAIT: begin
        if (next_cmd) begin                                                        // [RULE18]
          n.st      = lps_pkg::ST_ON;
          n.elapsed = 11'h000;
          tick_clr  = 1'b1;
        end
      end
      lps_pkg::ST_ON: begin
        if (tick) begin                                                            // [RULE20]
          n.elapsed = e1;
          n.judge   = (cur.pf_t != 10'h000) && (e1 == 11'(cur.pf_t));              // [RULE12]
          if (e1 == 11'(cur.on_t)) begin                                           // [RULE7]
            if (cur.off_t != 10'h000) begin
              n.st = lps_pkg::ST_OFF;                                              // [RULE8]
            end else begin
              adv = 1'b1;
            end
          end
        end
      end
      lps_pkg::ST_OFF: begin
        if (tick) begin
          n.elapsed = e1;
          n.judge   = (cur.pf_t != 10'h000) && (e1 == 11'(cur.pf_t));
          if (e1 == 11'(cur.on_t) + 11'(cur.off_t)) begin                          // [RULE8]
            adv = 1'b1;
          end
        end
      end
    endcase
    // Step advance and chain following
    if (adv) begin
      if (s.cur_step == 4'(lps_pkg::NUM_STEP - 1)) begin
        if (s.link[s.cur_prog] == lps_pkg::LINK_END) begin                         // [RULE16]
          n.st   = lps_pkg::ST_IDLE;
          n.done = 1'b1;
        end else begin
          n.cur_prog = s.link[s.cur_prog] - 4'h1;                                  // [RULE15] [RULE17]
          n.cur_step = 4'h0;
          n.st       = lps_pkg::ST_FETCH;
        end
      end else begin
        n.cur_step = s.cur_step + 4'h1;                                            // [RULE4]
        n.st       = lps_pkg::ST_FETCH;
      end
    end
    if (stop_cmd) begin
      n.st    = lps_pkg::ST_IDLE;                                                  // [RULE19]
      n.judge = 1'b0;
    end
    // Output staging from next state, read data from current state
    nx           = n.steps[step_idx(n.cur_prog, n.cur_step)];
    n.slot       = (n.st == lps_pkg::ST_ON || n.st == lps_pkg::ST_OFF) ? nx.slot : 7'h00;
    n.short_mask = 8'h00;
    if (n.st == lps_pkg::ST_ON && nx.ch != 4'h0 && nx.short_t != 10'h000 &&
        n.elapsed < 11'(nx.short_t)) begin                                         // [RULE10] [RULE11]
      n.short_mask = 8'h01 << (nx.ch - 4'h1);
    end
    if (RD_STB) begin
      case (ADDR)
        lps_pkg::ADDR_STATUS: begin
          n.rdata[lps_pkg::ST_RUN_BIT]        = (s.st != lps_pkg::ST_IDLE);
          n.rdata[lps_pkg::ST_WAIT_BIT]       = (s.st == lps_pkg::ST_WAIT);
          n.rdata[lps_pkg::ST_REJ_BIT]        = s.rej;
          n.rdata[lps_pkg::ST_DONE_BIT]       = s.done;
          n.rdata[lps_pkg::ST_PROG_LSB +: 4]  = s.cur_prog;
          n.rdata[lps_pkg::ST_STEP_LSB +: 4]  = s.cur_step;
          n.rdata[lps_pkg::ST_ELAPS_LSB +: 11] = s.elapsed;
        end
        lps_pkg::ADDR_SEL: begin
          n.rdata[lps_pkg::SEL_PROG_LSB +: 4] = s.sel_prog;
          n.rdata[lps_pkg::SEL_STEP_LSB +: 4] = s.sel_step;
        end
        lps_pkg::ADDR_STEP_A: begin
          n.rdata[lps_pkg::A_SLOT_LSB +: 7] = s.steps[wsel].slot;
          n.rdata[lps_pkg::A_RUN_LSB +: 2]  = s.steps[wsel].run;
          n.rdata[lps_pkg::A_CH_LSB +: 4]   = s.steps[wsel].ch;
        end
        lps_pkg::ADDR_STEP_B: begin
          n.rdata[lps_pkg::B_ON_LSB +: 10]  = s.steps[wsel].on_t;
          n.rdata[lps_pkg::B_OFF_LSB +: 10] = s.steps[wsel].off_t;
        end
        lps_pkg::ADDR_STEP_C: begin
          n.rdata[lps_pkg::C_SHORT_LSB +: 10] = s.steps[wsel].short_t;
          n.rdata[lps_pkg::C_PF_LSB +: 10]    = s.steps[wsel].pf_t;
        end
        lps_pkg::ADDR_CHAIN: n.rdata[3:0] = s.link[s.sel_prog];
        lps_pkg::ADDR_START: n.rdata[3:0] = s.start;
        lps_pkg::ADDR_CFG:   n.rdata[lps_pkg::CFG_LIMIT_BIT] = s.lim_en;
        default: begin
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      s       <= '0;
      s.st    <= lps_pkg::ST_IDLE;
      s.steps <= {lps_pkg::NUM_ENTRY{lps_pkg::STEP_RST}};                          // [RULE6]
      s.link  <= {lps_pkg::NUM_PROG{lps_pkg::LINK_END}};
      s.start <= lps_pkg::START_RST;
    end else begin
      s <= n;
    end
  end

  // Outputs
  assign RDATA           = s.rdata;
  assign LOAD_ON         = (s.st == lps_pkg::ST_ON);                               // [RULE3]
  assign SETTING_SLOT    = s.slot;
  assign SHORT_EN        = s.short_mask;
  assign JUDGE_PULSE     = s.judge;
  assign LIMIT_CHECK_ACT = s.lim_en && (s.st == lps_pkg::ST_ON || s.st == lps_pkg::ST_OFF); // [RULE13]
  assign RUNNING         = (s.st != lps_pkg::ST_IDLE);
  assign WAIT_NEXT       = (s.st == lps_pkg::ST_WAIT);

  // Checks
  a_short_in_on: assert property (@(posedge CORE_CLK) disable iff (!RST_B)  // [RULE10]
    SHORT_EN != 8'h00 |-> LOAD_ON && $onehot(SHORT_EN)) else $error("short outside load-on");
  a_stop_abort: assert property (@(posedge CORE_CLK) disable iff (!RST_B)  // [RULE19]
    stop_cmd |=> !RUNNING && !LOAD_ON) else $error("stop did not abort");
  a_manual_hold: assert property (@(posedge CORE_CLK) disable iff (!RST_B)  // [RULE18]
    WAIT_NEXT && !next_cmd && !stop_cmd |=> WAIT_NEXT) else $error("manual step left without next");
  a_auto_start: assert property (@(posedge CORE_CLK) disable iff (!RST_B)  // [RULE5]
    s.st == lps_pkg::ST_FETCH && cur.run == lps_pkg::RUN_AUTO && !stop_cmd
    |=> LOAD_ON && s.elapsed == 11'h000) else $error("auto step did not start");
  a_skip_pass: assert property (@(posedge CORE_CLK) disable iff (!RST_B)  // [RULE4]
    s.st == lps_pkg::ST_FETCH && cur.run == lps_pkg::RUN_SKIP && !stop_cmd && s.cur_step < 4'h9
    |=> !LOAD_ON && s.cur_step == $past(s.cur_step) + 4'h1) else $error("skip step mishandled");
  a_off_follow: assert property (@(posedge CORE_CLK) disable iff (!RST_B)  // [RULE8]
    LOAD_ON && tick && e1 == 11'(cur.on_t) && cur.off_t != 10'h000 && !stop_cmd
    |=> s.st == lps_pkg::ST_OFF) else $error("load-off did not follow load-on");
  a_judge_time: assert property (@(posedge CORE_CLK) disable iff (!RST_B)  // [RULE12]
    JUDGE_PULSE |-> $past(cur.pf_t) != 10'h000 && 11'($past(cur.pf_t)) == $past(s.elapsed) + 11'h001)
    else $error("judgement at wrong time");
  a_chain_end: assert property (@(posedge CORE_CLK) disable iff (!RST_B)  // [RULE16]
    adv && s.cur_step == 4'h9 && s.link[s.cur_prog] == lps_pkg::LINK_END && !stop_cmd
    |=> !RUNNING && s.done) else $error("chain end not honoured");
  a_chain_link: assert property (@(posedge CORE_CLK) disable iff (!RST_B)  // [RULE15]
    adv && s.cur_step == 4'h9 && s.link[s.cur_prog] != lps_pkg::LINK_END && !stop_cmd
    |=> s.cur_prog == $past(s.link[s.cur_prog]) - 4'h1 && s.cur_step == 4'h0) else $error("chain link wrong");
  a_short_reject: assert property (@(posedge CORE_CLK) disable iff (!RST_B)  // [RULE9]
    WR_STB && ADDR == lps_pkg::ADDR_STEP_C && w_sc > s.steps[wsel].on_t |=> s.rej)
    else $error("oversized short time accepted");

  c_manual_next: cover property (@(posedge CORE_CLK) disable iff (!RST_B) WAIT_NEXT ##1 LOAD_ON);
  c_short_seen: cover property (@(posedge CORE_CLK) disable iff (!RST_B) SHORT_EN != 8'h00);
  c_judge_seen: cover property (@(posedge CORE_CLK) disable iff (!RST_B) JUDGE_PULSE);
  c_chain_loop: cover property (@(posedge CORE_CLK) disable iff (!RST_B)
    adv && s.cur_step == 4'h9 && s.link[s.cur_prog] == s.cur_prog + 4'h1);

endmodule : lps_seq

// [verif/tb_top.sv]
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct {logic [5:0] a; logic [31:0] w; logic [31:0] e;} lps_row_t;

  logic        CORE_CLK;
  logic        RST_B;
  logic [5:0]  ADDR;
  logic [31:0] WDATA;
  logic        WR_STB;
  logic        RD_STB;
  logic [31:0] RDATA;
  logic        LOAD_ON;
  logic [6:0]  SETTING_SLOT;
  logic [7:0]  SHORT_EN;
  logic        JUDGE_PULSE;
  logic        LIMIT_CHECK_ACT;
  logic        RUNNING;
  logic        WAIT_NEXT;
  logic [31:0] rd;
  logic [7:0]  sh_or;
  logic [6:0]  slots [4];
  logic        prev;
  int          n_mismatch = 0;
  int          compares = 0;
  int          k, on_cyc, sh_cyc, jp, rises, lim_on;

  // Register table: write, read back, expected word
  lps_row_t rows [14] = '{
    '{lps_pkg::ADDR_SEL, 32'h00000095, 32'h00000095},
    '{lps_pkg::ADDR_SEL, 32'h0000000C, 32'h00000095},
    '{lps_pkg::ADDR_STEP_A, 32'h00008278, 32'h00008278},
    '{lps_pkg::ADDR_STEP_A, 32'h00000000, 32'h00008278},
    '{lps_pkg::ADDR_STEP_A, 32'h00000378, 32'h00008278},
    '{lps_pkg::ADDR_STEP_A, 32'h00009278, 32'h00008278},
    '{lps_pkg::ADDR_STEP_B, 32'h02580258, 32'h02580258},
    '{lps_pkg::ADDR_STEP_B, 32'h02590001, 32'h02580258},
    '{lps_pkg::ADDR_STEP_C, 32'h03FF0258, 32'h03FF0258},
    '{lps_pkg::ADDR_STEP_C, 32'h00000259, 32'h03FF0258},
    '{lps_pkg::ADDR_CHAIN, 32'h0000000C, 32'h0000000C},
    '{lps_pkg::ADDR_CHAIN, 32'h0000000D, 32'h0000000C},
    '{lps_pkg::ADDR_START, 32'h0000000B, 32'h0000000B},
    '{6'h24, 32'h0000FFFF, 32'h00000000}};

  lps_seq #(.TICK_CYCLES(4)) u_dut (
    .CORE_CLK        (CORE_CLK),
    .RST_B           (RST_B),
    .ADDR            (ADDR),
    .WDATA           (WDATA),
    .WR_STB          (WR_STB),
    .RD_STB          (RD_STB),
    .RDATA           (RDATA),
    .LOAD_ON         (LOAD_ON),
    .SETTING_SLOT    (SETTING_SLOT),
    .SHORT_EN        (SHORT_EN),
    .JUDGE_PULSE     (JUDGE_PULSE),
    .LIMIT_CHECK_ACT (LIMIT_CHECK_ACT),
    .RUNNING         (RUNNING),
    .WAIT_NEXT       (WAIT_NEXT)
  );

  // Clock, 40 ns period
  initial begin
    CORE_CLK = 1'b0;
    forever #20 CORE_CLK = ~CORE_CLK;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    @(posedge CORE_CLK);
    ADDR   <= a;
    WDATA  <= d;
    WR_STB <= 1'b1;
    @(posedge CORE_CLK);
    WR_STB <= 1'b0;
  endtask : wr

  // Read data stands only in the cycle after the strobe
  task automatic rdr(input logic [5:0] a);
    @(posedge CORE_CLK);
    ADDR   <= a;
    RD_STB <= 1'b1;
    @(posedge CORE_CLK);
    RD_STB <= 1'b0;
    @(negedge CORE_CLK);
    rd = RDATA;
  endtask : rdr

  task automatic set_step(input logic [7:0] sel, input logic [31:0] a, input logic [31:0] b, input logic [31:0] c);
    wr(lps_pkg::ADDR_SEL, {24'h000000, sel});
    wr(lps_pkg::ADDR_STEP_A, a);
    wr(lps_pkg::ADDR_STEP_B, b);
    wr(lps_pkg::ADDR_STEP_C, c);
  endtask : set_step

  // Watches the outputs until the run ends
  task automatic watch();
    on_cyc = 0; sh_cyc = 0; jp = 0; rises = 0; lim_on = 0; sh_or = 8'h00; prev = 1'b0;
    for (k = 0; k < 500 && RUNNING === 1'b1; k++) begin
      if (LOAD_ON === 1'b1 && !prev) begin
        slots[rises] = SETTING_SLOT;
        rises++;
      end
      prev = (LOAD_ON === 1'b1);
      on_cyc += prev;
      sh_cyc += (SHORT_EN !== 8'h00);
      sh_or |= SHORT_EN;
      jp += (JUDGE_PULSE === 1'b1);
      lim_on += (prev && LIMIT_CHECK_ACT === 1'b1);
      @(negedge CORE_CLK);
    end
  endtask : watch

  task automatic wait_on(input logic lvl);
    for (k = 0; k < 400 && LOAD_ON !== lvl; k++) @(negedge CORE_CLK);
    chk({31'h0, LOAD_ON}, {31'h0, lvl}, "load level");
  endtask : wait_on

  task automatic summarize();
    $display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : summarize

  // Watchdog, far beyond the expected run length
  initial begin
    #800000;
    n_mismatch++;
    summarize();
  end

  initial begin
    RST_B = 1'b0; ADDR = 6'h00; WDATA = 32'h00000000; WR_STB = 1'b0; RD_STB = 1'b0;
    repeat (12) @(posedge CORE_CLK);
    RST_B <= 1'b1;
    @(negedge CORE_CLK);
    chk({12'h000, LOAD_ON, SETTING_SLOT, SHORT_EN, JUDGE_PULSE, LIMIT_CHECK_ACT, RUNNING, WAIT_NEXT}, 0, "reset outs");
    rdr(lps_pkg::ADDR_STEP_A); chk(rd, 32'h00000001, "reset step a");
    rdr(lps_pkg::ADDR_STEP_B); chk(rd, 32'h00000001, "reset step b");
    $display("test reset done");
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].w);
      rdr(rows[i].a); chk(rd, rows[i].e, "table row");
    end
    rdr(lps_pkg::ADDR_STATUS); chk(rd & 32'h4, 32'h4, "reject set");
    wr(lps_pkg::ADDR_CTRL, 32'h8);
    rdr(lps_pkg::ADDR_STATUS); chk(rd & 32'h4, 32'h0, "reject clear");
    $display("test registers done");
    // Program 0: step 0 auto with short, step 2 auto with no channel
    set_step(8'h00, 32'h00003105, 32'h00010002, 32'h00020001);
    set_step(8'h20, 32'h00000106, 32'h00000001, 32'h00000001);
    wr(lps_pkg::ADDR_CFG, 32'h1);
    wr(lps_pkg::ADDR_START, 32'h0);
    wr(lps_pkg::ADDR_CTRL, 32'h1);
    @(negedge CORE_CLK); chk({31'h0, RUNNING}, 1, "running");
    @(negedge CORE_CLK); chk({31'h0, LOAD_ON}, 1, "load on");
    chk({25'h0, SETTING_SLOT}, 5, "slot");
    watch();
    chk(rises, 2, "steps run");
    chk({25'h0, slots[0]}, 5, "first step");
    chk({25'h0, slots[1]}, 6, "third step");
    chk(on_cyc, 12, "on cycles");
    chk(sh_cyc, 4, "short cycles");
    chk({24'h0, sh_or}, 32'h04, "short channel");
    chk(jp, 1, "judge pulses");
    chk(lim_on, on_cyc, "limit check");
    rdr(lps_pkg::ADDR_STATUS); chk(rd & 32'h9, 32'h8, "done");
    $display("test auto program done");
    // Chain 3 -> 1 -> 3, program 1 holds a manual step
    set_step(8'h03, 32'h00000109, 32'h00000001, 32'h00000000);
    wr(lps_pkg::ADDR_CHAIN, 32'h2);
    set_step(8'h01, 32'h00000207, 32'h00000001, 32'h00000000);
    wr(lps_pkg::ADDR_CHAIN, 32'h4);
    wr(lps_pkg::ADDR_START, 32'h3);
    wr(lps_pkg::ADDR_CTRL, 32'h1);
    wait_on(1'b1); chk({25'h0, SETTING_SLOT}, 9, "chain head");
    for (k = 0; k < 400 && WAIT_NEXT !== 1'b1; k++) @(negedge CORE_CLK);
    repeat (20) @(negedge CORE_CLK);
    chk({30'h0, WAIT_NEXT, LOAD_ON}, 2, "held");
    wr(lps_pkg::ADDR_CTRL, 32'h2);
    @(negedge CORE_CLK); chk({24'h0, LOAD_ON, SETTING_SLOT}, 32'h87, "next");
    wait_on(1'b0);
    wait_on(1'b1); chk({25'h0, SETTING_SLOT}, 9, "loop back");
    wr(lps_pkg::ADDR_CTRL, 32'h4);
    @(negedge CORE_CLK); chk({30'h0, RUNNING, LOAD_ON}, 0, "stop");
    $display("test chain and stop done");
    // Reset in mid-run clears state, selection and start program
    wr(lps_pkg::ADDR_CTRL, 32'h1);
    wait_on(1'b1);
    @(posedge CORE_CLK);
    RST_B <= 1'b0;
    repeat (3) @(posedge CORE_CLK);
    RST_B <= 1'b1;
    @(negedge CORE_CLK);
    chk({12'h000, LOAD_ON, SETTING_SLOT, SHORT_EN, JUDGE_PULSE, LIMIT_CHECK_ACT, RUNNING, WAIT_NEXT}, 0, "mid reset outs");
    rdr(lps_pkg::ADDR_SEL); chk(rd, 32'h00000000, "mid reset sel");
    @(negedge CORE_CLK); chk(RDATA, 32'h00000000, "read data idle");
    rdr(lps_pkg::ADDR_START); chk(rd, 32'h00000000, "mid reset start");
    $display("test mid-run reset done");
    summarize();
  end
endmodule : tb_top
